// ===== cc_ctl.sv
// Capture/compare channel configuration, capture gating and output enable table
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// RULE1 - Capture prescaler divides events by 1,2,4,8
// RULE2 - Prescaler count cleared while channel disabled
// RULE3 - Direction 00 output, 01 own, 10 neighbour
// RULE4 - Channels 3/4 swap inputs on select 10
// RULE5 - Select 11 routes internal trigger input
// RULE6 - Direction writable only while channel disabled
// RULE7 - Pair 3/4 mode register output layout
// RULE8 - Pair 3/4 mode register input layout
// RULE9 - Enable register bit layout, 15:14 reserved
// RULE10 - Complementary polarity 0 high, 1 low
// RULE11 - Lock level 2+ blocks polarity writes
// RULE12 - Polarity sets output level or capture edge
// RULE13 - Enable gates capture into capture register
// RULE14 - Disabled output undriven low when run-off 0
// RULE15 - Lone enabled output drives reference xor polarity
// RULE16 - Both enabled: reference and inverse, polarity applied
// RULE17 - Run-off 1, both off: undriven at polarity
// RULE18 - Run-off 1, one on: partner driven inactive
// RULE19 - Software clears idle/polarity bits when unused
// RULE20 - Compare mode three-bit encoding exposed
// RULE21 - Four-bit filter code exposed per channel
// RULE22 - Break clears main output enable asynchronously; here it clears on a clock edge, after a two-flop synchroniser
module cc_ctl (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire cc_ctl_pkg::chan_in_t  chan_in,
  input  wire logic                  break_in,
  output cc_ctl_pkg::chan_out_t      chan_out,
  output logic      [3:0]            capture_strobe,
  output logic      [3:0]            capture_edge
);
  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] pair12_mode_reg;
  logic [15:0] pair34_mode_reg;
  logic [15:0] enable_reg;
  logic [15:0] break_ctl_reg;
  logic [3:0]  pin_s1_reg, pin_s2_reg, pin_d_reg;
  logic [3:0]  trg_s1_reg, trg_s2_reg, trg_d_reg;
  logic [3:0]  brk_s1_reg, brk_s2_reg;
  logic [2:0]  psc_cnt_reg [cc_ctl_pkg::NCH];
  logic [3:0]  chan_edge;
  logic        wr_en;
  logic        rd_en;
  logic        lock_hi;

  function automatic logic [7:0] chan_byte(input logic [1:0] ch, input logic [15:0] r12,
                                           input logic [15:0] r34);
    logic [15:0] r;
    r = ch[1] ? r34 : r12;
    return ch[0] ? r[15:8] : r[7:0];
  endfunction : chan_byte

  function automatic logic [2:0] psc_limit(input logic [1:0] code);
    return (3'h1 << code) - 3'h1;
  endfunction : psc_limit

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign lock_hi = break_ctl_reg[cc_ctl_pkg::BRK_LOCK_LSB +: 2] >= cc_ctl_pkg::LOCK_LEVEL2;

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers; direction field masked while the channel is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair12_mode_reg <= cc_ctl_pkg::MODE_RESET;
      pair34_mode_reg <= cc_ctl_pkg::MODE_RESET;
    end else if (wr_en) begin
      for (int c = 0; c < cc_ctl_pkg::NCH; c++) begin
        if ((c < 2 && paddr == cc_ctl_pkg::OFF_PAIR12_MODE) ||
            (c >= 2 && paddr == cc_ctl_pkg::OFF_PAIR34_MODE)) begin
          // RULE7 channel byte placement
          // RULE8 filter and prescaler share byte
          if (c == 0) pair12_mode_reg[7:2] <= pwdata[7:2];
          if (c == 1) pair12_mode_reg[15:10] <= pwdata[15:10];
          if (c == 2) pair34_mode_reg[7:2] <= pwdata[7:2];
          if (c == 3) pair34_mode_reg[15:10] <= pwdata[15:10];
          // RULE6 direction write gate
          if (!enable_reg[c*cc_ctl_pkg::EN_STRIDE + cc_ctl_pkg::EN_OE]) begin
            if (c == 0) pair12_mode_reg[1:0] <= pwdata[1:0];
            if (c == 1) pair12_mode_reg[9:8] <= pwdata[9:8];
            if (c == 2) pair34_mode_reg[1:0] <= pwdata[1:0];
            if (c == 3) pair34_mode_reg[9:8] <= pwdata[9:8];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable/polarity register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_reg <= cc_ctl_pkg::ENABLE_RESET;
    end else if (wr_en && paddr == cc_ctl_pkg::OFF_ENABLE_POL) begin
      for (int c = 0; c < cc_ctl_pkg::NCH; c++) begin
        enable_reg[c*4 + cc_ctl_pkg::EN_OE] <= pwdata[c*4 + cc_ctl_pkg::EN_OE];
        // RULE11 polarity lock
        if (!lock_hi) enable_reg[c*4 + cc_ctl_pkg::EN_POL] <= pwdata[c*4 + cc_ctl_pkg::EN_POL];
        // RULE9 channel four has no complementary pair
        if (c < 3) begin
          enable_reg[c*4 + cc_ctl_pkg::EN_NE] <= pwdata[c*4 + cc_ctl_pkg::EN_NE];
          if (!(lock_hi && chan_byte(2'(c), pair12_mode_reg, pair34_mode_reg)[1:0] ==
                cc_ctl_pkg::DIR_OUTPUT))
            enable_reg[c*4 + cc_ctl_pkg::EN_NPOL] <= pwdata[c*4 + cc_ctl_pkg::EN_NPOL];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Break control; lock level writable only while it reads zero, then held until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_ctl_reg <= 16'h0000;
    end else begin
      if (wr_en && paddr == cc_ctl_pkg::OFF_BREAK_CTL) begin
        break_ctl_reg[cc_ctl_pkg::BRK_MOE_BIT]    <= pwdata[cc_ctl_pkg::BRK_MOE_BIT];
        break_ctl_reg[cc_ctl_pkg::BRK_RUNOFF_BIT] <= pwdata[cc_ctl_pkg::BRK_RUNOFF_BIT];
        break_ctl_reg[cc_ctl_pkg::BRK_TS_LSB +: 3] <= pwdata[cc_ctl_pkg::BRK_TS_LSB +: 3];
        if (break_ctl_reg[cc_ctl_pkg::BRK_LOCK_LSB +: 2] == 2'h0)
          break_ctl_reg[cc_ctl_pkg::BRK_LOCK_LSB +: 2] <= pwdata[cc_ctl_pkg::BRK_LOCK_LSB +: 2];
      end
      // RULE22 break wins over a software set
      if (brk_s2_reg[1]) break_ctl_reg[cc_ctl_pkg::BRK_MOE_BIT] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; break synchronised too, since all outputs are flopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_d_reg  <= 4'h0;
      trg_s1_reg <= 4'h0;
      trg_s2_reg <= 4'h0;
      trg_d_reg  <= 4'h0;
      brk_s1_reg <= 4'h0;
      brk_s2_reg <= 4'h0;
    end else begin
      pin_s1_reg <= chan_in.pin_in;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
      trg_s1_reg <= chan_in.trig_in;
      trg_s2_reg <= trg_s1_reg;
      trg_d_reg  <= trg_s2_reg;
      brk_s1_reg <= {3'h0, break_in};
      brk_s2_reg <= {brk_s1_reg[0], brk_s1_reg[0], 2'h0} >> 2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input mapping and edge selection
  always_comb begin
    for (int c = 0; c < cc_ctl_pkg::NCH; c++) begin
      logic [7:0] b;
      logic       cur;
      logic       prv;
      int         nb;
      b   = chan_byte(2'(c), pair12_mode_reg, pair34_mode_reg);
      nb  = c ^ 1;
      cur = 1'b0;
      prv = 1'b0;
      // RULE3 own or neighbour input
      // RULE4 pair swap
      // RULE5 internal trigger only when selected
      case (b[1:0])
        cc_ctl_pkg::DIR_OWN:       begin cur = pin_s2_reg[c];  prv = pin_d_reg[c];  end
        cc_ctl_pkg::DIR_NEIGHBOUR: begin cur = pin_s2_reg[nb]; prv = pin_d_reg[nb]; end
        cc_ctl_pkg::DIR_TRIGGER: begin
          if (break_ctl_reg[cc_ctl_pkg::BRK_TS_LSB +: 3] <= cc_ctl_pkg::TS_INTERNAL_MAX) begin
            cur = trg_s2_reg[c];
            prv = trg_d_reg[c];
          end
        end
        default: begin cur = 1'b0; prv = 1'b0; end
      endcase
      // RULE12 polarity picks rising or falling edge
      chan_edge[c] = enable_reg[c*4 + cc_ctl_pkg::EN_POL] ? (prv && !cur) : (!prv && cur);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Capture prescaler and gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < cc_ctl_pkg::NCH; c++) psc_cnt_reg[c] <= 3'h0;
      capture_strobe <= 4'h0;
      capture_edge   <= 4'h0;
    end else begin
      for (int c = 0; c < cc_ctl_pkg::NCH; c++) begin
        logic [1:0] psc;
        psc = chan_byte(2'(c), pair12_mode_reg, pair34_mode_reg)[cc_ctl_pkg::CH_PSC_LSB +: 2];
        capture_edge[c]   <= chan_edge[c];
        capture_strobe[c] <= 1'b0;
        // RULE2 count held clear while off
        if (!enable_reg[c*4 + cc_ctl_pkg::EN_OE]) begin
          psc_cnt_reg[c] <= 3'h0;
        end else if (chan_edge[c]) begin
          // RULE1 divide by 1,2,4,8
          if (psc_cnt_reg[c] >= psc_limit(psc)) begin
            psc_cnt_reg[c] <= 3'h0;
            // RULE13 capture only while enabled
            capture_strobe[c] <= 1'b1;
          end else begin
            psc_cnt_reg[c] <= psc_cnt_reg[c] + 3'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output table; dead-time lives downstream, so both-enabled gives plain complements
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_out <= '{main_lvl: 4'h0, main_drv_n: 4'hf, comp_lvl: 4'h0, comp_drv_n: 4'hf};
    end else begin
      for (int c = 0; c < cc_ctl_pkg::NCH; c++) begin
        logic oe, ne, p, np, rf, run_offstate_select, main_output_enable, isout;
        oe    = enable_reg[c*4 + cc_ctl_pkg::EN_OE];
        ne    = (c < 3) ? enable_reg[c*4 + cc_ctl_pkg::EN_NE] : 1'b0;
        p     = enable_reg[c*4 + cc_ctl_pkg::EN_POL];
        np    = (c < 3) ? enable_reg[c*4 + cc_ctl_pkg::EN_NPOL] : 1'b0;
        rf    = chan_in.ref_lvl[c];
        run_offstate_select  = break_ctl_reg[cc_ctl_pkg::BRK_RUNOFF_BIT];
        main_output_enable   = break_ctl_reg[cc_ctl_pkg::BRK_MOE_BIT] && !brk_s2_reg[1];
        isout = chan_byte(2'(c), pair12_mode_reg, pair34_mode_reg)[1:0] == cc_ctl_pkg::DIR_OUTPUT;
        chan_out.main_lvl[c]   <= 1'b0;
        chan_out.main_drv_n[c] <= 1'b1;
        chan_out.comp_lvl[c]   <= 1'b0;
        chan_out.comp_drv_n[c] <= 1'b1;
        if (main_output_enable && isout) begin
          // RULE15 lone output, RULE16 paired outputs
          if (oe) begin
            chan_out.main_lvl[c]   <= rf ^ p;
            chan_out.main_drv_n[c] <= 1'b0;
          end
          // RULE10 complementary polarity
          if (ne) begin
            chan_out.comp_lvl[c]   <= (oe ? !rf : rf) ^ np;
            chan_out.comp_drv_n[c] <= 1'b0;
          end
          // RULE17 undriven at polarity level
          // RULE18 partner held inactive
          if (run_offstate_select) begin
            if (!oe) begin
              chan_out.main_lvl[c]   <= p;
              chan_out.main_drv_n[c] <= !ne;
            end
            if (!ne && c < 3) begin
              chan_out.comp_lvl[c]   <= np;
              chan_out.comp_drv_n[c] <= !oe;
            end
          end
          // RULE14 disabled outputs float low when run-off is clear
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data registered in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !(paddr inside {cc_ctl_pkg::OFF_PAIR12_MODE,
                 cc_ctl_pkg::OFF_PAIR34_MODE, cc_ctl_pkg::OFF_ENABLE_POL,
                 cc_ctl_pkg::OFF_BREAK_CTL, cc_ctl_pkg::OFF_STATUS});
      if (rd_en) begin
        // RULE20 compare mode and RULE21 filter codes read back as stored
        case (paddr)
          cc_ctl_pkg::OFF_PAIR12_MODE: prdata <= {16'h0000, pair12_mode_reg};
          cc_ctl_pkg::OFF_PAIR34_MODE: prdata <= {16'h0000, pair34_mode_reg};
          cc_ctl_pkg::OFF_ENABLE_POL:
            prdata <= {16'h0000, enable_reg & cc_ctl_pkg::ENABLE_RSVD_MASK};
          cc_ctl_pkg::OFF_BREAK_CTL:   prdata <= {16'h0000, break_ctl_reg};
          cc_ctl_pkg::OFF_STATUS:
            prdata <= {24'h000000, capture_edge, pin_s2_reg};
          default:                     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  AST_PSC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_reg[0] |=> psc_cnt_reg[0] == 3'h0) else $error("prescaler not cleared"); // RULE2
  AST_NO_CAPTURE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !enable_reg[4] |=> !capture_strobe[1]) else $error("capture while disabled"); // RULE13
  AST_PSC_DIV1: assert property (@(posedge pclk) disable iff (!presetn)
    enable_reg[0] && chan_edge[0] && pair12_mode_reg[3:2] == 2'h0 |=> capture_strobe[0])
    else $error("undivided capture missing"); // RULE1
  AST_RSVD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    rd_en && paddr == cc_ctl_pkg::OFF_ENABLE_POL |=> prdata[15:14] == 2'h0)
    else $error("reserved bits nonzero"); // RULE9
  AST_DIR_LOCKED: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == cc_ctl_pkg::OFF_PAIR34_MODE && enable_reg[8] |=>
    $stable(pair34_mode_reg[1:0])) else $error("direction changed while on"); // RULE6
  AST_POL_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
    lock_hi |=> $stable(enable_reg[1])) else $error("polarity changed under lock"); // RULE11
  AST_BREAK_MOE: assert property (@(posedge pclk) disable iff (!presetn)
    brk_s2_reg[1] |=> !break_ctl_reg[cc_ctl_pkg::BRK_MOE_BIT] && chan_out.main_drv_n == 4'hf)
    else $error("break did not clear outputs"); // RULE22
  AST_LONE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
    break_ctl_reg[15] && !brk_s2_reg[1] && pair12_mode_reg[1:0] == 2'h0 && enable_reg[0] &&
    !enable_reg[2] |=> !chan_out.main_drv_n[0] &&
    chan_out.main_lvl[0] == ($past(chan_in.ref_lvl[0]) ^ $past(enable_reg[1])))
    else $error("lone output level wrong"); // RULE15
  AST_OFF_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
    !break_ctl_reg[11] && !enable_reg[0] |=> chan_out.main_drv_n[0] && !chan_out.main_lvl[0])
    else $error("disabled output driven"); // RULE14
  COV_CAPTURE: cover property (@(posedge pclk) disable iff (!presetn) capture_strobe[2]);
  COV_PAIR: cover property (@(posedge pclk) disable iff (!presetn)
    !chan_out.main_drv_n[0] && !chan_out.comp_drv_n[0]);
  COV_BREAK: cover property (@(posedge pclk) disable iff (!presetn) brk_s2_reg[1]);
endmodule : cc_ctl

// ===== cc_ctl_pkg.sv
// Register map, field layout and shared types for the capture/compare control block
package cc_ctl_pkg;
  localparam logic [7:0]  OFF_PAIR34_MODE   = 8'h1c;
  localparam logic [7:0]  OFF_ENABLE_POL    = 8'h20;
  localparam logic [7:0]  OFF_PAIR12_MODE   = 8'h18;
  localparam logic [7:0]  OFF_BREAK_CTL     = 8'h44;
  localparam logic [7:0]  OFF_STATUS        = 8'h48;
  localparam logic [15:0] MODE_RESET        = 16'h0000;
  localparam logic [15:0] ENABLE_RESET      = 16'h0000;
  localparam logic [15:0] ENABLE_RSVD_MASK  = 16'h3fff;
  // Break/control register fields
  localparam int          BRK_MOE_BIT       = 15;
  localparam int          BRK_RUNOFF_BIT    = 11;
  localparam int          BRK_LOCK_LSB      = 8;
  localparam int          BRK_TS_LSB        = 0;
  // Per-channel field positions within a channel byte
  localparam int          CH_DIR_LSB        = 0;
  localparam int          CH_PSC_LSB        = 2;
  localparam int          CH_FILT_LSB       = 4;
  localparam int          CH_MODE_LSB       = 4;
  localparam int          CH_STRIDE         = 8;
  // Enable register nibble layout
  localparam int          EN_OE             = 0;
  localparam int          EN_POL            = 1;
  localparam int          EN_NE             = 2;
  localparam int          EN_NPOL           = 3;
  localparam int          EN_STRIDE         = 4;
  localparam logic [1:0]  DIR_OUTPUT        = 2'h0;
  localparam logic [1:0]  DIR_OWN           = 2'h1;
  localparam logic [1:0]  DIR_NEIGHBOUR     = 2'h2;
  localparam logic [1:0]  DIR_TRIGGER       = 2'h3;
  localparam logic [2:0]  TS_INTERNAL_MAX   = 3'h3;
  localparam logic [1:0]  LOCK_LEVEL2       = 2'h2;
  localparam int          NCH               = 4;

  typedef struct packed {
    logic [3:0] ref_lvl;
    logic [3:0] pin_in;
    logic [3:0] trig_in;
  } chan_in_t;

  typedef struct packed {
    logic [3:0] main_lvl;
    logic [3:0] main_drv_n;
    logic [3:0] comp_lvl;
    logic [3:0] comp_drv_n;
  } chan_out_t;
endpackage : cc_ctl_pkg

// ===== cc_ctl_tb.sv
// Self-checking testbench for the capture/compare control block
`timescale 1ns/1ps
module cc_ctl_tb;
  logic                  pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, break_in = 0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0, prdata, rdv;
  logic                  pready, pslverr, erv;
  logic [3:0]            ref_r = 4'h0, pins, trigs, strobe, cap_edge;
  cc_ctl_pkg::chan_in_t  chan_in;
  cc_ctl_pkg::chan_out_t chan_out;
  int                    scnt[4], ecnt[4], err_total = 0, checked = 0;
  // Rows: enable nibble {np,ne,p,oe}, run off-state, reference, {main,drv_n,comp,drv_n}
  localparam logic [9:0] ROWS [10] = '{10'b0000_0_1_0101, 10'b0100_0_1_0110,
    10'b1100_0_1_0100, 10'b0001_0_1_1001, 10'b0011_0_1_0001, 10'b0101_0_1_1000,
    10'b1111_0_1_0010, 10'b0000_1_1_0101, 10'b1001_1_0_0010, 10'b0110_1_1_1010};

  assign chan_in = {ref_r, pins, trigs};
  always #5 pclk = ~pclk;

  cc_ctl u_cc_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chan_in(chan_in), .break_in(break_in), .chan_out(chan_out),
    .capture_strobe(strobe), .capture_edge(cap_edge));
  pin_model u_pin_model (.pclk(pclk), .main_lvl(chan_out.main_lvl),
    .main_drv_n(chan_out.main_drv_n), .pin_in(pins), .trig_in(trigs));

  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      scnt[i] += int'(strobe[i]);
      ecnt[i] += int'(cap_edge[i]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) err_total++;
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rdv, e);
  endtask : rdchk

  task run(input int idx, input int n, input logic trig);
    @(negedge pclk);
    scnt = '{default: 0};
    ecnt = '{default: 0};
    u_pin_model.toggle(idx, n, trig, 6);
    repeat (8) @(posedge pclk);
  endtask : run

  task do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    err_total++;
    stop_test;
  end

  initial begin
    do_reset;
    for (int r = 0; r < 10; r++) begin
      ref_r <= {4{ROWS[r][4]}};
      wr(8'h44, 32'h8000 | (32'(ROWS[r][5]) << 11));
      wr(8'h20, {20'h0, ROWS[r][9:6], ROWS[r][9:6], ROWS[r][9:6]});
      repeat (2) @(posedge pclk);
      check({chan_out.main_lvl[2:0], chan_out.main_drv_n[2:0], chan_out.comp_lvl[2:0],
             chan_out.comp_drv_n[2:0]}, {20'h0, {3{ROWS[r][3]}}, {3{ROWS[r][2]}},
             {3{ROWS[r][1]}}, {3{ROWS[r][0]}}});
    end
    // main enabled, complementary disabled, polarity cleared before break test
    wr(8'h20, 32'h1);
    wr(8'h44, 32'h8000);
    @(posedge pclk);
    break_in <= 1'b1;
    repeat (5) @(posedge pclk);
    check(32'(chan_out.main_drv_n), 32'hf);
    break_in <= 1'b0;
    rdchk(8'h44, 32'h0);
    wr(8'h20, 32'h0);
    rdchk(8'h24, 32'h0);
    check(32'(erv), 32'h1);
    wr(8'h20, 32'hffff);
    rdchk(8'h20, 32'h3fff);
    wr(8'h20, 32'h0);
    wr(8'h1c, 32'hffff_fefe);
    rdchk(8'h1c, 32'h0000_fefe);
    for (int k = 0; k < 4; k++) begin
      wr(8'h20, 32'h0);
      wr(8'h18, 32'((k << 2) | 1));
      wr(8'h20, 32'h1);
      run(0, 16, 1'b0);
      check(32'(scnt[0]), 32'(8 >> k));
    end
    // prescaler cleared by disable, no capture while off
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h9);
    wr(8'h20, 32'h1);
    run(0, 6, 1'b0);
    wr(8'h20, 32'h0);
    run(0, 4, 1'b0);
    check(32'(scnt[0]), 32'h0);
    check(32'(ecnt[0]), 32'h2);
    wr(8'h20, 32'h1);
    run(0, 4, 1'b0);
    check(32'(scnt[0]), 32'h0);
    run(0, 4, 1'b0);
    check(32'(scnt[0]), 32'h1);
    // inverted input captures falling edges only
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h0100);
    wr(8'h20, 32'h0030);
    run(1, 1, 1'b0);
    check(32'(scnt[1]), 32'h0);
    run(1, 1, 1'b0);
    check(32'(scnt[1]), 32'h1);
    // trigger input only with internal source
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h3);
    wr(8'h20, 32'h1);
    run(0, 2, 1'b1);
    check(32'(scnt[0]), 32'h1);
    wr(8'h44, 32'h4);
    run(0, 2, 1'b1);
    check(32'(scnt[0]), 32'h0);
    wr(8'h44, 32'h0);
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h0002);
    wr(8'h1c, 32'h0602);
    wr(8'h20, 32'h1101);
    run(2, 8, 1'b0);
    check({scnt[3][15:0], scnt[2][15:0]}, 32'h0002_0000);
    run(3, 4, 1'b0);
    check({scnt[3][15:0], scnt[2][15:0]}, 32'h0000_0002);
    run(1, 2, 1'b0);
    check(32'(scnt[0]), 32'h1);
    // lock and direction guard after a second reset
    do_reset;
    rdchk(8'h20, 32'h0);
    wr(8'h1c, 32'h1);
    wr(8'h20, 32'h1);
    wr(8'h18, 32'h1);
    rdchk(8'h18, 32'h0);
    wr(8'h44, 32'h0200);
    wr(8'h20, 32'hffff);
    rdchk(8'h20, 32'h1d55);
    stop_test;
  end
endmodule : cc_ctl_tb

// ===== pin_model.sv
// Far-side model of the channel pins and internal trigger lines
`timescale 1ns/1ps
module pin_model (
  input  wire logic       pclk,
  input  wire logic [3:0] main_lvl,
  input  wire logic [3:0] main_drv_n,
  output logic      [3:0] pin_in,
  output logic      [3:0] trig_in
);
  logic [3:0] ext_lvl;

  initial begin
    ext_lvl = 4'h0;
    trig_in = 4'h0;
  end

  // The timer owns the pin while it drives it, else the far side level shows
  assign pin_in = (main_drv_n & ext_lvl) | (~main_drv_n & main_lvl);

  // Each toggle is held for gap+1 cycles so the 2-FF sync always sees it
  task automatic toggle(input int idx, input int n, input logic trig, input int gap);
    repeat (n) begin
      @(posedge pclk);
      if (trig) begin
        trig_in[idx] <= ~trig_in[idx];
      end else begin
        ext_lvl[idx] <= ~ext_lvl[idx];
      end
      repeat (gap) @(posedge pclk);
    end
  endtask : toggle
endmodule : pin_model
